// ---- dusc_pkg.sv ----
// Shared constants for the converter update and serial write control block
`default_nettype none

package dusc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame layout
    localparam int unsigned FRAME_BITS = 24;
    localparam int unsigned ADDR_MSB   = 23;
    localparam int unsigned ADDR_LSB   = 16;
    localparam int unsigned DATA_MSB   = 15;
    localparam int unsigned DATA_LSB   = 0;
    localparam int unsigned DATA_BITS  = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADDR_SYNC_CFG   = 8'h02;
    localparam logic [7:0] ADDR_POWER_DOWN = 8'h03;
    localparam logic [7:0] ADDR_RANGE      = 8'h04;
    localparam logic [7:0] ADDR_TRIGGER    = 8'h05;
    localparam logic [7:0] ADDR_CODE       = 8'h08;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned SYNC_EN_BIT    = 0;
    localparam int unsigned AMP_OFF_BIT    = 0;
    localparam int unsigned REF_OFF_BIT    = 8;
    localparam int unsigned OUT_DBL_BIT    = 0;
    localparam int unsigned REF_HALVE_BIT  = 8;
    localparam int unsigned LOAD_TRIG_BIT  = 4;
    localparam int unsigned SOFT_RST_MSB   = 3;
    localparam int unsigned SOFT_RST_LSB   = 0;
    localparam logic [3:0]  SOFT_RST_CODE  = 4'ha;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic SYNC_EN_RST   = 1'h0;
    localparam logic AMP_OFF_RST   = 1'h0;
    localparam logic REF_OFF_RST   = 1'h0;
    localparam logic OUT_DBL_RST   = 1'h1;
    localparam logic REF_HALVE_RST = 1'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned POR_DELAY_NS  = 250000;
    localparam int unsigned POR_CYCLES    =
        (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : dusc_pkg

`default_nettype wire

// ---- dusc_link_rx.sv ----
// Serial-clock side receiver: shifts the 24-bit write frame
`default_nettype none

module dusc_link_rx (
    input  wire logic        i_rst_n,
    input  wire logic        i_sclk,
    input  wire logic        i_sync_n,
    input  wire logic        i_serial_data_in,
    output logic [23:0]      o_word,
    output logic             o_full
);

    typedef struct packed {
        logic        seen;
        logic [4:0]  cnt;
        logic [23:0] shift;
    } dusc_rx_state_type;

    dusc_rx_state_type s_r;
    dusc_rx_state_type s_nxt;
    logic              frame_tog_r;

    ////////////////////////////////////////////////////////////////////////////
    // Marks each frame start; the serial clock may be stopped outside frames,
    // so the start is taken from the frame-select edge itself
    always_ff @(negedge i_sync_n or negedge i_rst_n) begin
        if (!i_rst_n) begin
            frame_tog_r <= 1'b0;
        end else begin
            frame_tog_r <= ~frame_tog_r;
        end
    end

    always_comb begin
        s_nxt = s_r;
        if (!i_sync_n) begin
            if (frame_tog_r != s_r.seen) begin
                // New frame: stale bits of an aborted frame are dropped
                s_nxt.seen  = frame_tog_r;
                s_nxt.cnt   = 5'h01;
                s_nxt.shift = {23'h000000, i_serial_data_in};
            end else begin
                s_nxt.shift = {s_r.shift[22:0], i_serial_data_in};
                if (s_r.cnt != 5'(dusc_pkg::FRAME_BITS)) begin
                    s_nxt.cnt = s_r.cnt + 5'h01;
                end
            end
        end
    end

    // Data is taken on falling serial clock edges, only while selected
    always_ff @(negedge i_sclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_word = s_r.shift;
    // A frame that opened but saw no serial edge leaves the old count behind;
    // the toggle mismatch keeps that old word from being taken a second time
    assign o_full = (s_r.cnt == 5'(dusc_pkg::FRAME_BITS))
        && (frame_tog_r == s_r.seen);

endmodule : dusc_link_rx

`default_nettype wire

// ---- dusc_top.sv ----
// Converter update control: serial write port, code registers, modes
`default_nettype none

module dusc_top #(
    parameter int unsigned RESOLUTION = 16,
    parameter bit          MIDSCALE   = 1'b0,
    parameter int unsigned POR_CYCLES = dusc_pkg::POR_CYCLES
) (
    input  wire logic                  I_CLK,
    input  wire logic                  I_RST_N,
    input  wire logic                  I_SCLK,
    input  wire logic                  I_SYNC_N,
    input  wire logic                  I_SERIAL_DATA_IN,
    input  wire logic                  I_INTERFACE_SELECT_PIN,
    input  wire logic                  I_TWOWIRE_UPDATE,
    input  wire logic                  I_HEADROOM_LOW,
    output logic [RESOLUTION-1:0]      O_ACTIVE_CODE,
    output logic [15:0]                O_BUFFER_CODE,
    output logic                       O_OUTPUT_DOUBLING,
    output logic                       O_REF_HALVE,
    output logic                       O_REF_ENABLE,
    output logic                       O_REF_BUF_ENABLE,
    output logic                       O_AMP_POWER_DOWN,
    output logic                       O_OUTPUT_ZERO,
    output logic                       O_REF_ALARM,
    output logic                       O_SPI_MODE,
    output logic                       O_READY
);

    localparam int unsigned CW = $clog2(POR_CYCLES + 1);

    // Power-up code, placed in the upper bits of the 16-bit data field
    localparam logic [RESOLUTION-1:0] CODE_RST =
        MIDSCALE ? {1'b1, {(RESOLUTION-1){1'b0}}} : '0;
    // Shifted rather than padded, so a full 16-bit code needs no empty replication
    localparam logic [15:0] BUF_RST =
        16'(CODE_RST) << (16 - RESOLUTION);

    typedef struct packed {
        logic [2:0]            syn;
        logic                  syn_lvl;
        logic [2:0]            sel;
        logic [2:0]            hdr;
        logic                  hdr_lvl;
        logic [1:0]            fill;
        logic [CW-1:0]         por_cnt;
        logic                  ready;
        logic                  strap_done;
        logic                  spi_mode;
        logic                  sync_en;
        logic                  amp_off;
        logic                  ref_off;
        logic                  ref_halve;
        logic                  out_dbl;
        logic [15:0]           buffer;
        logic [RESOLUTION-1:0] active;
        logic                  alarm;
        logic                  soft_rst;
        logic                  ref_en;
        logic                  buf_en;
    } dusc_state_type;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic [1:0] rst_pipe_r;
    logic       rst_n;

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_pipe_r <= 2'h0;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // Serial-clock side

    logic [23:0] rx_word;
    logic        rx_full;

    // Works on falling serial edges only, so a free-running or a gated
    // serial clock behaves the same
    dusc_link_rx u_link_rx (
        .i_rst_n  (rst_n),
        .i_sclk   (I_SCLK),
        .i_sync_n (I_SYNC_N),
        .i_serial_data_in   (I_SERIAL_DATA_IN),
        .o_word   (rx_word),
        .o_full   (rx_full)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Main state

    dusc_state_type s_r;
    dusc_state_type s_nxt;

    logic        sync_rise;
    logic        accept;
    logic [7:0]  f_addr;
    logic [15:0] f_data;
    logic        load_now;

    function automatic dusc_state_type defaults(input dusc_state_type cur);
        dusc_state_type d;
        d            = '0;
        // Synchroniser pipes keep their contents across a soft reset, but hold still for that one cycle
        d.syn        = cur.syn;
        d.syn_lvl    = cur.syn_lvl;
        d.sel        = cur.sel;
        d.hdr        = cur.hdr;
        d.hdr_lvl    = cur.hdr_lvl;
        d.fill       = cur.fill;
        d.sync_en    = dusc_pkg::SYNC_EN_RST;
        d.amp_off    = dusc_pkg::AMP_OFF_RST;
        d.ref_off    = dusc_pkg::REF_OFF_RST;
        d.ref_halve  = dusc_pkg::REF_HALVE_RST;
        d.out_dbl    = dusc_pkg::OUT_DBL_RST;
        d.buffer     = BUF_RST;
        d.active     = CODE_RST;
        return d;
    endfunction : defaults

    always_comb begin
        s_nxt     = s_r;
        sync_rise = 1'b0;
        accept    = 1'b0;
        f_addr    = rx_word[dusc_pkg::ADDR_MSB:dusc_pkg::ADDR_LSB];
        f_data    = rx_word[dusc_pkg::DATA_MSB:dusc_pkg::DATA_LSB];
        load_now  = 1'b0;

        // Pin synchronisers: a change counts once stages two and three agree
        s_nxt.syn = {s_r.syn[1:0], I_SYNC_N};
        s_nxt.sel = {s_r.sel[1:0], I_INTERFACE_SELECT_PIN};
        s_nxt.hdr = {s_r.hdr[1:0], I_HEADROOM_LOW};
        if (s_r.syn[1] == s_r.syn[2]) begin
            s_nxt.syn_lvl = s_r.syn[2];
            sync_rise     = s_r.syn[2] & ~s_r.syn_lvl;
        end
        if (s_r.hdr[1] == s_r.hdr[2]) begin
            s_nxt.hdr_lvl = s_r.hdr[2];
        end

        // Host access is held off for the power-on delay
        if (!s_r.ready) begin
            if (s_r.por_cnt == CW'(POR_CYCLES - 1)) begin
                s_nxt.ready = 1'b1;
            end else begin
                s_nxt.por_cnt = s_r.por_cnt + CW'(1);
            end
        end

        // The strap pipe starts from its reset value, so it is not trusted
        // until the pin has walked through all three stages
        if (s_r.fill != 2'h3) begin
            s_nxt.fill = s_r.fill + 2'h1;
        end

        // Interface choice is taken once and re-read only after a soft reset
        if (!s_r.strap_done && (s_r.fill == 2'h3)
                && (s_r.sel[1] == s_r.sel[2])) begin
            s_nxt.strap_done = 1'b1;
            s_nxt.spi_mode   = ~s_r.sel[2];
        end

        // The receiver word is quiet by now: the serial side stops shifting
        // as soon as select goes high, long before the synchronised edge
        if (sync_rise && rx_full && s_r.ready && s_r.strap_done
                && s_r.spi_mode) begin
            accept = 1'b1;
        end
        // A short frame never sets rx_full and so changes nothing

        if (accept) begin
            case (f_addr)
                dusc_pkg::ADDR_SYNC_CFG: begin
                    s_nxt.sync_en = f_data[dusc_pkg::SYNC_EN_BIT];
                end
                dusc_pkg::ADDR_POWER_DOWN: begin
                    s_nxt.amp_off = f_data[dusc_pkg::AMP_OFF_BIT];
                    s_nxt.ref_off = f_data[dusc_pkg::REF_OFF_BIT];
                end
                dusc_pkg::ADDR_RANGE: begin
                    s_nxt.ref_halve = f_data[dusc_pkg::REF_HALVE_BIT];
                    s_nxt.out_dbl   = f_data[dusc_pkg::OUT_DBL_BIT];
                end
                dusc_pkg::ADDR_TRIGGER: begin
                    // Action bits are never stored, so they read as spent
                    if (f_data[dusc_pkg::SOFT_RST_MSB:dusc_pkg::SOFT_RST_LSB]
                            == dusc_pkg::SOFT_RST_CODE) begin
                        s_nxt.soft_rst = 1'b1;
                    end
                    if (f_data[dusc_pkg::LOAD_TRIG_BIT] && s_r.sync_en) begin
                        load_now = 1'b1;
                    end
                end
                dusc_pkg::ADDR_CODE: begin
                    s_nxt.buffer = f_data;
                    if (!s_r.sync_en) begin
                        s_nxt.active = f_data[15 -: RESOLUTION];
                    end
                end
                default: begin
                    // Unmapped addresses are ignored
                end
            endcase
        end

        // Update instant handed in by the two-wire engine
        if (I_TWOWIRE_UPDATE && s_r.strap_done && !s_r.spi_mode
                && !s_r.sync_en) begin
            load_now = 1'b1;
        end

        if (load_now) begin
            s_nxt.active = s_r.buffer[15 -: RESOLUTION];
        end

        // Soft reset restores every default and restarts the access delay
        if (s_r.soft_rst) begin
            s_nxt = defaults(s_r);
        end

        // Divider too low for the headroom; codes stay untouched. Worked out
        // after the soft reset so the alarm does not blink off across it
        s_nxt.alarm = s_r.hdr_lvl & ~s_r.ref_halve;

        // Enables kept as flops of their own so the pins need no inverter
        s_nxt.ref_en = ~s_nxt.ref_off;
        s_nxt.buf_en = ~s_nxt.alarm;
    end

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_r            <= '0;
            s_r.syn        <= 3'h7;
            s_r.syn_lvl    <= 1'b1;
            s_r.sync_en    <= dusc_pkg::SYNC_EN_RST;
            s_r.amp_off    <= dusc_pkg::AMP_OFF_RST;
            s_r.ref_off    <= dusc_pkg::REF_OFF_RST;
            s_r.ref_halve  <= dusc_pkg::REF_HALVE_RST;
            s_r.out_dbl    <= dusc_pkg::OUT_DBL_RST;
            s_r.buffer     <= BUF_RST;
            s_r.active     <= CODE_RST;
            s_r.ref_en     <= ~dusc_pkg::REF_OFF_RST;
            s_r.buf_en     <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state flops

    assign O_ACTIVE_CODE     = s_r.active;
    assign O_BUFFER_CODE     = s_r.buffer;
    assign O_OUTPUT_DOUBLING = s_r.out_dbl;
    assign O_REF_HALVE       = s_r.ref_halve;
    assign O_REF_ENABLE      = s_r.ref_en;
    assign O_REF_BUF_ENABLE  = s_r.buf_en;
    assign O_AMP_POWER_DOWN  = s_r.amp_off;
    assign O_OUTPUT_ZERO     = s_r.alarm;
    assign O_REF_ALARM       = s_r.alarm;
    assign O_SPI_MODE        = s_r.spi_mode;
    assign O_READY           = s_r.ready;

endmodule : dusc_top

`default_nettype wire

// ---- dusc_top_sva.sv ----
// Concurrent property checker for the update and serial write control block
`default_nettype none

module dusc_top_sva #(
    parameter int unsigned RESOLUTION = 16,
    parameter bit          MIDSCALE   = 1'b0,
    parameter int unsigned POR_CYCLES = 20
) (
    input wire logic                  I_CLK,
    input wire logic                  I_RST_N,
    input wire logic                  I_SYNC_N,
    input wire logic                  I_INTERFACE_SELECT_PIN,
    input wire logic                  I_HEADROOM_LOW,
    input wire logic [RESOLUTION-1:0] O_ACTIVE_CODE,
    input wire logic [15:0]           O_BUFFER_CODE,
    input wire logic                  O_OUTPUT_DOUBLING,
    input wire logic                  O_REF_HALVE,
    input wire logic                  O_REF_ENABLE,
    input wire logic                  O_REF_BUF_ENABLE,
    input wire logic                  O_OUTPUT_ZERO,
    input wire logic                  O_REF_ALARM,
    input wire logic                  O_SPI_MODE,
    input wire logic                  O_READY
);
    localparam logic [15:0] RST_CODE = MIDSCALE ? 16'h8000 : 16'h0000;

    int unsigned wait_r;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    ////////////////////////////////////////////////////////////////////////////
    // Cycles spent in the start-up delay; a soft reset restarts it too
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) wait_r <= 32'h0;
        else if (O_READY) wait_r <= 32'h0;
        else wait_r <= wait_r + 32'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    reset_default_a: assert property (
        $rose(I_RST_N) |-> O_OUTPUT_DOUBLING && O_REF_ENABLE && !O_REF_HALVE
            && O_BUFFER_CODE == RST_CODE)
        else $error("outputs not at defaults after reset");
    code_follows_a: assert property (
        $changed(O_ACTIVE_CODE) |-> O_ACTIVE_CODE == O_BUFFER_CODE[15 -: RESOLUTION])
        else $error("active code differs from buffer on update");
    frame_quiet_a: assert property (
        (O_SPI_MODE && !I_SYNC_N) [*8] |-> $stable(O_BUFFER_CODE) && $stable(O_ACTIVE_CODE))
        else $error("code changed inside a frame");
    alarm_on_a: assert property (
        (I_HEADROOM_LOW && !O_REF_HALVE) [*8] |-> O_REF_ALARM)
        else $error("alarm missing");
    alarm_off_a: assert property (
        (!I_HEADROOM_LOW || O_REF_HALVE) [*8] |-> !O_REF_ALARM)
        else $error("alarm stuck");
    alarm_effect_a: assert property (
        O_OUTPUT_ZERO == O_REF_ALARM && O_REF_BUF_ENABLE == !O_REF_ALARM)
        else $error("alarm effects wrong");
    idle_hold_a: assert property (
        !O_READY && !$fell(O_READY) |-> $stable(O_BUFFER_CODE) && $stable(O_ACTIVE_CODE))
        else $error("code changed before ready");
    ready_early_a: assert property (
        $rose(O_READY) |-> wait_r >= POR_CYCLES)
        else $error("ready too early");
    ready_late_a: assert property (
        !O_READY |-> wait_r <= POR_CYCLES + 12)
        else $error("ready too late");
    mode_strap_a: assert property (
        $rose(O_SPI_MODE) |-> !I_INTERFACE_SELECT_PIN)
        else $error("serial mode against strap");
    mode_kept_a: assert property (
        O_SPI_MODE && O_READY |=> O_SPI_MODE || !O_READY)
        else $error("serial mode lost");
endmodule : dusc_top_sva

bind dusc_top dusc_top_sva #(
    .RESOLUTION(RESOLUTION), .MIDSCALE(MIDSCALE), .POR_CYCLES(POR_CYCLES)
) u_dusc_top_sva (
    .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_SYNC_N(I_SYNC_N),
    .I_INTERFACE_SELECT_PIN(I_INTERFACE_SELECT_PIN), .I_HEADROOM_LOW(I_HEADROOM_LOW),
    .O_ACTIVE_CODE(O_ACTIVE_CODE), .O_BUFFER_CODE(O_BUFFER_CODE),
    .O_OUTPUT_DOUBLING(O_OUTPUT_DOUBLING), .O_REF_HALVE(O_REF_HALVE),
    .O_REF_ENABLE(O_REF_ENABLE), .O_REF_BUF_ENABLE(O_REF_BUF_ENABLE),
    .O_OUTPUT_ZERO(O_OUTPUT_ZERO), .O_REF_ALARM(O_REF_ALARM),
    .O_SPI_MODE(O_SPI_MODE), .O_READY(O_READY)
);

`default_nettype wire

// ---- dusc_host_model.sv ----
// Serial host model: drives frame select, serial clock and data
`default_nettype none

module dusc_host_model (
    output logic o_sclk,
    output logic o_sync_n,
    output logic o_serial_data_in
);
    timeunit 1ns;
    timeprecision 100ps;

    logic gate;
    logic free_run;

    initial begin
        o_sclk = 1'b1;
        o_sync_n = 1'b1;
        o_serial_data_in = 1'b0;
        gate = 1'b0;
        free_run = 1'b0;
    end

    // Clock idles high between frames unless told to run free
    always begin
        #15;
        if (gate || free_run) o_sclk = ~o_sclk;
    end

    task automatic send(input logic [23:0] w, input int unsigned n);
        logic [23:0] sh;
        sh = w;
        o_serial_data_in = sh[23];
        o_sync_n = 1'b0;
        gate = 1'b1;
        for (int unsigned i = 0; i < n; i++) begin
            o_serial_data_in = sh[23];
            @(negedge o_sclk);
            #2;
            sh = sh << 1;
        end
        @(posedge o_sclk);
        gate = 1'b0;
        #10;
        o_sync_n = 1'b1;
        // Released line shows the inverse so a stale bit never passes as data
        o_serial_data_in = ~o_serial_data_in;
        #200;
    endtask : send
endmodule : dusc_host_model

`default_nettype wire

// ---- dusc_top_bench.sv ----
// Self-checking bench for the update and serial write control block
`default_nettype none

module dusc_top_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // Start-up delay shortened so the run stays brief
    localparam int unsigned POR_SIM = 20;

    logic        clk;
    logic        rst_n;
    logic        sclk;
    logic        sync_n;
    logic        serial_data_in;
    logic        sel_pin;
    logic        tw_upd;
    logic        headroom;
    logic [15:0] active;
    logic [15:0] buffer;
    logic [15:0] flags;
    logic        dbl, halve, ref_en, buf_en, amp_pd, zero, alarm, spi, ready;
    int          fail_count;
    int          cmp_count;

    assign flags = {8'h0, alarm, zero, buf_en, dbl, halve, ref_en, amp_pd, spi};

    always #10 clk = ~clk;

    dusc_top #(.POR_CYCLES(POR_SIM)) u_dusc_top (
        .I_CLK(clk), .I_RST_N(rst_n), .I_SCLK(sclk), .I_SYNC_N(sync_n),
        .I_SERIAL_DATA_IN(serial_data_in), .I_INTERFACE_SELECT_PIN(sel_pin),
        .I_TWOWIRE_UPDATE(tw_upd), .I_HEADROOM_LOW(headroom),
        .O_ACTIVE_CODE(active), .O_BUFFER_CODE(buffer), .O_OUTPUT_DOUBLING(dbl),
        .O_REF_HALVE(halve), .O_REF_ENABLE(ref_en), .O_REF_BUF_ENABLE(buf_en),
        .O_AMP_POWER_DOWN(amp_pd), .O_OUTPUT_ZERO(zero), .O_REF_ALARM(alarm),
        .O_SPI_MODE(spi), .O_READY(ready)
    );

    dusc_host_model u_dusc_host_model (.o_sclk(sclk), .o_sync_n(sync_n), .o_serial_data_in(serial_data_in));

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wait_ready();
        for (int i = 0; i < 400 && ready !== 1'b1; i++) @(posedge clk);
        repeat (4) @(posedge clk);
        #1;
        chk(16'(ready), 16'h0001);
    endtask : wait_ready

    // One-cycle update instant as a two-wire engine would hand it in
    task automatic tw_pulse();
        tw_upd = 1'b1;
        @(posedge clk);
        #1;
        tw_upd = 1'b0;
    endtask : tw_pulse

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input int unsigned n);
        u_dusc_host_model.send({a, d}, n);
        repeat (10) @(posedge clk);
        #1;
    endtask : wr

    task automatic do_reset(input logic pin);
        rst_n = 1'b0;
        sel_pin = pin;
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        wait_ready();
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        fail_count++;
        wrap_up();
    end

    initial begin
        clk = 1'b0;
        tw_upd = 1'b0;
        headroom = 1'b0;
        fail_count = 0;
        cmp_count = 0;
        do_reset(1'b0);
        chk(flags, 16'h0035);
        chk(active, 16'h0000);
        wr(8'h08, 16'h1234, 24);
        chk(buffer, 16'h1234);
        chk(active, 16'h1234);
        wr(8'h08, 16'hbeef, 23);
        chk(buffer, 16'h1234);
        chk(active, 16'h1234);
        wr(8'h04, 16'h0100, 24);
        chk(flags, 16'h002d);
        wr(8'h04, 16'h0001, 24);
        wr(8'h03, 16'h0101, 24);
        chk(flags, 16'h0033);
        wr(8'h03, 16'h0000, 24);
        wr(8'h02, 16'h0001, 24);
        wr(8'h08, 16'ha5a5, 24);
        chk(buffer, 16'ha5a5);
        chk(active, 16'h1234);
        tw_pulse();
        chk(active, 16'h1234);
        wr(8'h05, 16'h0003, 24);
        chk(16'(ready), 16'h0001);
        chk(active, 16'h1234);
        wr(8'h05, 16'h0010, 24);
        chk(active, 16'ha5a5);
        headroom = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk(flags, 16'h00d5);
        chk(active, 16'ha5a5);
        wr(8'h04, 16'h0101, 24);
        chk(flags, 16'h003d);
        headroom = 1'b0;
        wr(8'h04, 16'h0001, 24);
        u_dusc_host_model.free_run = 1'b1;
        wr(8'h02, 16'h0000, 24);
        wr(8'h08, 16'h0f0f, 24);
        chk(active, 16'h0f0f);
        u_dusc_host_model.free_run = 1'b0;
        wr(8'h07, 16'hffff, 24);
        chk(buffer, 16'h0f0f);
        chk(flags, 16'h0035);
        wr(8'h05, 16'h000a, 24);
        chk(16'(ready), 16'h0000);
        chk(active, 16'h0000);
        wait_ready();
        chk(buffer, 16'h0000);
        do_reset(1'b1);
        chk(flags, 16'h0034);
        wr(8'h08, 16'h5555, 24);
        chk(buffer, 16'h0000);
        tw_pulse();
        chk(active, 16'h0000);
        wrap_up();
    end
endmodule : dusc_top_bench

`default_nettype wire
